// *** core/ruc_update_ctrl.sv ***
// register update control: shadow and active banks with selectable update events
// assumes a host writing over the three-wire serial port, vertical sync from a pin,
// and the internal timing signals on the system clock
`timescale 1ns/1ns
module ruc_update_ctrl
  import ruc_pkg::*;
(
  input  wire logic                   CLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic                   SCK_I,
  input  wire logic                   SL_I,
  input  wire logic                   SDATA_I,
  input  wire logic                   VD_I,
  input  wire logic [RUC_GPO_W-1:0]   GPO_NORMAL_I,
  input  wire logic                   OUTPUT_GATE_CONTROL_I,
  input  wire logic                   HORIZONTAL_BLANKING_I,
  input  wire logic                   OPTICAL_BLACK_CLAMP_I,
  input  wire logic                   PIXEL_BLANKING_I,
  input  wire logic                   VERTICAL_CLOCK_15_I,
  input  wire logic                   VERTICAL_CLOCK_24_I,
  input  wire logic [RUC_ADDR_W-1:0]  RD_ADDR_I,
  output logic      [RUC_DATA_W-1:0]  RD_DATA_O,
  output logic      [RUC_GPO_W-1:0]   GPO_O,
  output logic                        VERTICAL_CLOCK_24_O,
  output logic      [RUC_DATA_W-1:0]  STARTUP_O,
  output logic                        IMM_UPDATE_O,
  output logic                        FRAME_UPDATE_O
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam logic [RUC_CNT_W-1:0] MIN_BITS = RUC_CNT_W'(RUC_ADDR_W + 1);

  logic [RUC_ADDR_W-1:0]   rx_addr;
  logic [RUC_DATA_W-1:0]   rx_data;
  logic [RUC_CNT_W-1:0]    rx_bits;
  logic [1:0]              pin_sync;
  logic                    sl_sync;
  logic                    vd_sync;
  logic                    sl_d_reg;
  logic                    vd_d_reg;
  logic                    sl_rise;
  logic                    vd_rise;
  logic                    wr_stb;
  logic                    wr_bank;
  logic [RUC_BANK_AW-1:0]  wr_idx;
  logic                    wr_imm;
  logic                    wr_frm;

  logic [RUC_MASK_W-1:0]   fe_imm_reg;
  logic [RUC_MASK_W-1:0]   fe_frm_reg;
  logic [RUC_MASK_W-1:0]   misc_imm_reg;
  logic [RUC_MASK_W-1:0]   misc_frm_reg;
  logic [RUC_MASK_W-1:0]   sync_imm_reg;
  logic [RUC_MASK_W-1:0]   sync_frm_reg;
  logic [RUC_OBS_W-1:0]    obs_ctrl_reg;
  logic [RUC_SWAP_W-1:0]   swap_ctrl_reg;
  logic [RUC_DATA_W-1:0]   startup_reg;

  logic [RUC_DATA_W-1:0]   shadow_mem [RUC_BANK_DEPTH];
  logic [RUC_DATA_W-1:0]   active_mem [RUC_BANK_DEPTH];
  logic [RUC_BANK_DEPTH-1:0] pending_reg;
  logic [RUC_BANK_DEPTH-1:0] pending_next;

  logic [RUC_DATA_W-1:0]   rd_next;
  logic [RUC_GPO_W-1:0]    gpo_next;

  // ************************************************************
  // helper functions
  // ************************************************************
  function automatic logic in_bank(input logic [RUC_ADDR_W-1:0] a);
    in_bank = (a >= RUC_FE_BASE) && (a <= RUC_BANK_END);
  endfunction

  // picks the mask bit of one address out of the three group masks
  function automatic logic mask_bit(
    input logic [RUC_MASK_W-1:0]  fe_m,
    input logic [RUC_MASK_W-1:0]  misc_m,
    input logic [RUC_MASK_W-1:0]  sync_m,
    input logic [RUC_ADDR_W-1:0]  a
  );
    logic [3:0] pos;
    pos = a[3:0];
    if (a < RUC_MISC_BASE)
      mask_bit = fe_m[pos];
    else if (a < RUC_SYNC_BASE)
      mask_bit = misc_m[pos];
    else
      mask_bit = sync_m[pos];
  endfunction

  // ************************************************************
  // serial receiver on the serial clock
  // ************************************************************
  ruc_serial_rx u_rx (
    .sck_i   (SCK_I),
    .sl_i    (SL_I),
    .sdata_i (SDATA_I),
    .addr_o  (rx_addr),
    .data_o  (rx_data),
    .bits_o  (rx_bits)
  );

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  ruc_sync2 #(
    .W (2)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i ({VD_I, ~SL_I}),
    .sync_o  (pin_sync)
  );

  // strobe goes through inverted so the reset value matches its idle high
  assign sl_sync = ~pin_sync[0];
  assign vd_sync = pin_sync[1];

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sl_d_reg <= 1'b1;
      vd_d_reg <= 1'b0;
    end
    else
    begin
      sl_d_reg <= sl_sync;
      vd_d_reg <= vd_sync;
    end
  end

  assign sl_rise = sl_sync & ~sl_d_reg;
  assign vd_rise = vd_sync & ~vd_d_reg;

  // receiver outputs stay still while the strobe is high, so they are taken here
  assign wr_stb  = sl_rise && (rx_bits >= MIN_BITS);
  assign wr_bank = wr_stb && in_bank(rx_addr);
  assign wr_idx  = rx_addr[RUC_BANK_AW-1:0];
  assign wr_imm  = mask_bit(fe_imm_reg, misc_imm_reg, sync_imm_reg, rx_addr);
  assign wr_frm  = mask_bit(fe_frm_reg, misc_frm_reg, sync_frm_reg, rx_addr);

  // ************************************************************
  // update masks, take effect at the strobe
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      fe_imm_reg   <= RUC_FE_IMM_RST;
      fe_frm_reg   <= RUC_FE_FRM_RST;
      misc_imm_reg <= RUC_MISC_IMM_RST;
      misc_frm_reg <= RUC_MISC_FRM_RST;
      sync_imm_reg <= RUC_SYNC_IMM_RST;
      sync_frm_reg <= RUC_SYNC_FRM_RST;
    end
    else if (wr_stb)
    begin
      case (rx_addr)
        RUC_FE_IMM_OFS:   fe_imm_reg   <= rx_data[RUC_MASK_W-1:0];
        RUC_FE_FRM_OFS:   fe_frm_reg   <= rx_data[RUC_MASK_W-1:0];
        RUC_MISC_IMM_OFS: misc_imm_reg <= rx_data[RUC_MASK_W-1:0];
        RUC_MISC_FRM_OFS: misc_frm_reg <= rx_data[RUC_MASK_W-1:0];
        RUC_SYNC_IMM_OFS: sync_imm_reg <= rx_data[RUC_MASK_W-1:0];
        RUC_SYNC_FRM_OFS: sync_frm_reg <= rx_data[RUC_MASK_W-1:0];
        default:          ;
      endcase
    end
  end

  // ************************************************************
  // extra registers, take effect at the strobe
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      obs_ctrl_reg  <= RUC_OBS_CTRL_RST;
      swap_ctrl_reg <= RUC_SWAP_RST;
      startup_reg   <= RUC_STARTUP_RST;
    end
    else if (wr_stb)
    begin
      case (rx_addr)
        RUC_OBS_CTRL_OFS:  obs_ctrl_reg  <= rx_data[RUC_OBS_W-1:0];
        RUC_SWAP_CTRL_OFS: swap_ctrl_reg <= rx_data[RUC_SWAP_W-1:0];
        RUC_STARTUP_OFS:   startup_reg   <= rx_data;
        default:           ;
      endcase
    end
  end

  // ************************************************************
  // shadow bank: every banked write lands here, an immediate one in the same cycle as in the active bank
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (wr_bank)
      shadow_mem[wr_idx] <= rx_data;
  end

  // ************************************************************
  // pending frame updates, a new write wins over the clear
  // ************************************************************
  always_comb
  begin
    pending_next = pending_reg;
    if (vd_rise)
      pending_next = '0;
    if (wr_bank && !wr_imm && wr_frm)
      pending_next[wr_idx] = 1'b1;
    if (wr_bank && wr_imm)
      pending_next[wr_idx] = 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      pending_reg <= '0;
    else
      pending_reg <= pending_next;
  end

  // ************************************************************
  // active bank: frame copy, then immediate write on top
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      for (int i = 0; i < RUC_BANK_DEPTH; i++)
        active_mem[i] <= '0;
    end
    else
    begin
      if (vd_rise)
      begin
        for (int i = 0; i < RUC_BANK_DEPTH; i++)
          if (pending_reg[i])
            active_mem[i] <= shadow_mem[i];
      end
      if (wr_bank && wr_imm)
        active_mem[wr_idx] <= rx_data;
    end
  end

  // ************************************************************
  // update event pulses
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      IMM_UPDATE_O   <= 1'b0;
      FRAME_UPDATE_O <= 1'b0;
    end
    else
    begin
      IMM_UPDATE_O   <= wr_bank && wr_imm;
      FRAME_UPDATE_O <= vd_rise && (pending_reg != '0);
    end
  end

  // ************************************************************
  // read port of active bank and control registers
  // ************************************************************
  always_comb
  begin
    rd_next = '0;
    if (in_bank(RD_ADDR_I))
      rd_next = active_mem[RD_ADDR_I[RUC_BANK_AW-1:0]];
    else
    begin
      case (RD_ADDR_I)
        RUC_FE_IMM_OFS:    rd_next = {12'h000, fe_imm_reg};
        RUC_FE_FRM_OFS:    rd_next = {12'h000, fe_frm_reg};
        RUC_MISC_IMM_OFS:  rd_next = {12'h000, misc_imm_reg};
        RUC_MISC_FRM_OFS:  rd_next = {12'h000, misc_frm_reg};
        RUC_SYNC_IMM_OFS:  rd_next = {12'h000, sync_imm_reg};
        RUC_SYNC_FRM_OFS:  rd_next = {12'h000, sync_frm_reg};
        RUC_OBS_CTRL_OFS:  rd_next = {18'h00000, obs_ctrl_reg};
        RUC_SWAP_CTRL_OFS: rd_next = {26'h0000000, swap_ctrl_reg};
        RUC_STARTUP_OFS:   rd_next = startup_reg;
        default:           rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      RD_DATA_O <= '0;
    else
      RD_DATA_O <= rd_next;
  end

  // ************************************************************
  // general outputs 5 to 8 and vertical clock 24 pin
  // ************************************************************
  always_comb
  begin
    if (obs_ctrl_reg[RUC_OBS_EN_BIT])
      gpo_next = {PIXEL_BLANKING_I, OPTICAL_BLACK_CLAMP_I,
                  HORIZONTAL_BLANKING_I, OUTPUT_GATE_CONTROL_I};
    else
      gpo_next = GPO_NORMAL_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      GPO_O               <= '0;
      VERTICAL_CLOCK_24_O <= 1'b0;
    end
    else
    begin
      GPO_O <= gpo_next;
      if (swap_ctrl_reg[RUC_SWAP_BIT])
        VERTICAL_CLOCK_24_O <= VERTICAL_CLOCK_15_I;
      else
        VERTICAL_CLOCK_24_O <= VERTICAL_CLOCK_24_I;
    end
  end

  // ************************************************************
  // start-up register output, recommended value is host duty
  // ************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      STARTUP_O <= RUC_STARTUP_RST;
    else
      STARTUP_O <= startup_reg;
  end

endmodule

// *** include/ruc_pkg.sv ***
// package for the register update control block
// holds offsets, reset values, field positions and sizes shared by the design files
package ruc_pkg;

  // ************************************************************
  // serial frame layout
  // ************************************************************
  localparam int RUC_ADDR_W     = 8;
  localparam int RUC_DATA_W     = 28;
  localparam int RUC_CNT_W      = 6;
  localparam int RUC_FRAME_BITS = RUC_ADDR_W + RUC_DATA_W;
  localparam int RUC_MASK_W     = 16;
  localparam int RUC_BANK_DEPTH = 48;
  localparam int RUC_BANK_AW    = 6;

  // ************************************************************
  // double-buffered address groups
  // ************************************************************
  localparam logic [7:0] RUC_FE_BASE   = 8'h00;
  localparam logic [7:0] RUC_MISC_BASE = 8'h10;
  localparam logic [7:0] RUC_SYNC_BASE = 8'h20;
  localparam logic [7:0] RUC_BANK_END  = 8'h2F;

  // ************************************************************
  // update control and extra register offsets
  // ************************************************************
  localparam logic [7:0] RUC_FE_IMM_OFS    = 8'hB0;
  localparam logic [7:0] RUC_FE_FRM_OFS    = 8'hB1;
  localparam logic [7:0] RUC_MISC_IMM_OFS  = 8'hB2;
  localparam logic [7:0] RUC_MISC_FRM_OFS  = 8'hB3;
  localparam logic [7:0] RUC_SYNC_IMM_OFS  = 8'hB4;
  localparam logic [7:0] RUC_SYNC_FRM_OFS  = 8'hB5;
  localparam logic [7:0] RUC_OBS_CTRL_OFS  = 8'hD4;
  localparam logic [7:0] RUC_SWAP_CTRL_OFS = 8'hD7;
  localparam logic [7:0] RUC_STARTUP_OFS   = 8'hD8;

  // ************************************************************
  // reset values and the recommended start-up value
  // ************************************************************
  localparam logic [15:0] RUC_FE_IMM_RST   = 16'h1803;
  localparam logic [15:0] RUC_FE_FRM_RST   = 16'hE7FC;
  localparam logic [15:0] RUC_MISC_IMM_RST = 16'hF8FD;
  localparam logic [15:0] RUC_MISC_FRM_RST = 16'h0702;
  localparam logic [15:0] RUC_SYNC_IMM_RST = 16'hFFF9;
  localparam logic [15:0] RUC_SYNC_FRM_RST = 16'h0006;
  localparam logic [9:0]  RUC_OBS_CTRL_RST = 10'h000;
  localparam logic [1:0]  RUC_SWAP_RST     = 2'h0;
  localparam logic [27:0] RUC_STARTUP_RST  = 28'h0000000;
  localparam logic [27:0] RUC_STARTUP_REC  = 28'h0000888;

  // ************************************************************
  // field positions and widths
  // ************************************************************
  localparam int RUC_OBS_W       = 10;
  localparam int RUC_SWAP_W      = 2;
  localparam int RUC_OBS_EN_BIT  = 1;
  localparam int RUC_SWAP_BIT    = 1;
  localparam int RUC_GPO_W       = 4;

endpackage

// *** core/ruc_sync2.sv ***
// two flip-flop synchroniser for single-bit levels
// assumes each bit is a level that changes slowly against the clock
`timescale 1ns/1ns
module ruc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // ************************************************************
  // first stage feeds only the second stage
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_o   <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// *** core/ruc_serial_rx.sv ***
// serial write receiver on the serial clock
// assumes address then data, lsb first, sampled on the clock rising edge
// while the load strobe is low; the strobe high restarts the frame
`timescale 1ns/1ns
module ruc_serial_rx
  import ruc_pkg::*;
(
  input  wire logic                  sck_i,
  input  wire logic                  sl_i,
  input  wire logic                  sdata_i,
  output logic      [RUC_ADDR_W-1:0] addr_o,
  output logic      [RUC_DATA_W-1:0] data_o,
  output logic      [RUC_CNT_W-1:0]  bits_o
);

  localparam logic [RUC_CNT_W-1:0] FRAME_BITS = RUC_CNT_W'(RUC_FRAME_BITS);
  localparam logic [RUC_CNT_W-1:0] ADDR_BITS  = RUC_CNT_W'(RUC_ADDR_W);

  logic                 armed_reg;
  logic [RUC_CNT_W-1:0] bit_idx;

  // ************************************************************
  // bit counter, held after the frame so the commit can read it
  // ************************************************************
  always_ff @(posedge sck_i or posedge sl_i)
  begin
    if (sl_i)
      armed_reg <= 1'b1;
    else
      armed_reg <= 1'b0;
  end

  // first clock of a frame restarts at bit 0
  assign bit_idx = armed_reg ? '0 : bits_o;

  always_ff @(posedge sck_i)
  begin
    if (!sl_i && bit_idx != FRAME_BITS)
      bits_o <= bit_idx + 1'b1;
  end

  // ************************************************************
  // address and data shift
  // ************************************************************
  always_ff @(posedge sck_i)
  begin
    if (!sl_i)
    begin
      if (bit_idx < ADDR_BITS)
        addr_o[bit_idx[2:0]] <= sdata_i;
      if (bit_idx == '0)
        data_o <= '0;
      else if (bit_idx >= ADDR_BITS && bit_idx != FRAME_BITS)
        data_o[5'(bit_idx - ADDR_BITS)] <= sdata_i;
    end
  end

endmodule

// *** testbench/ruc_update_ctrl_assertions.sv ***
// checker for the register update control block
// sees only the top module ports; bound below
`timescale 1ns/1ns
module ruc_update_ctrl_chk
  import ruc_pkg::*;
(
  input wire logic                  CLK_I,
  input wire logic                  SYS_RST_I,
  input wire logic                  SL_I,
  input wire logic                  VD_I,
  input wire logic [RUC_GPO_W-1:0]  GPO_NORMAL_I,
  input wire logic                  OUTPUT_GATE_CONTROL_I,
  input wire logic                  HORIZONTAL_BLANKING_I,
  input wire logic                  OPTICAL_BLACK_CLAMP_I,
  input wire logic                  PIXEL_BLANKING_I,
  input wire logic                  VERTICAL_CLOCK_15_I,
  input wire logic                  VERTICAL_CLOCK_24_I,
  input wire logic [RUC_ADDR_W-1:0] RD_ADDR_I,
  input wire logic [RUC_DATA_W-1:0] RD_DATA_O,
  input wire logic [RUC_GPO_W-1:0]  GPO_O,
  input wire logic                  VERTICAL_CLOCK_24_O,
  input wire logic [RUC_DATA_W-1:0] STARTUP_O,
  input wire logic                  IMM_UPDATE_O,
  input wire logic                  FRAME_UPDATE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_imm_one_cycle: assert property (IMM_UPDATE_O |=> !IMM_UPDATE_O)
    else $error("immediate pulse too long");
  chk_frame_one_cycle: assert property (FRAME_UPDATE_O |=> !FRAME_UPDATE_O)
    else $error("frame pulse too long");
  chk_imm_after_strobe: assert property (IMM_UPDATE_O |-> SL_I && $past(SL_I, 3) && !$past(SL_I, 4))
    else $error("immediate update without strobe rise");
  chk_frame_after_sync: assert property (FRAME_UPDATE_O |-> $past(VD_I, 3) && !$past(VD_I, 4))
    else $error("frame update without sync rise");
  chk_bank_hold: assert property ($past(RD_ADDR_I) == $past(RD_ADDR_I, 2) && $past(RD_ADDR_I) <= RUC_BANK_END
      && !$past(SYS_RST_I, 2) && $changed(RD_DATA_O) |-> $past(IMM_UPDATE_O) || $past(FRAME_UPDATE_O))
    else $error("bank value changed without update event");
  chk_startup_strobe: assert property ($changed(STARTUP_O) && !$past(SYS_RST_I) |-> SL_I)
    else $error("start-up value changed outside a write");
  chk_obs_route: assert property (!$past(SYS_RST_I) |-> GPO_O == $past(GPO_NORMAL_I)
      || GPO_O == $past({PIXEL_BLANKING_I, OPTICAL_BLACK_CLAMP_I, HORIZONTAL_BLANKING_I, OUTPUT_GATE_CONTROL_I}))
    else $error("general outputs carry neither source");
  chk_swap_route: assert property (!$past(SYS_RST_I) |-> VERTICAL_CLOCK_24_O == $past(VERTICAL_CLOCK_24_I)
      || VERTICAL_CLOCK_24_O == $past(VERTICAL_CLOCK_15_I))
    else $error("clock 24 pin carries neither clock");
  chk_reset_quiet: assert property (disable iff (1'b0) SYS_RST_I |=> RD_DATA_O == '0 && GPO_O == '0
      && STARTUP_O == '0 && !IMM_UPDATE_O && !FRAME_UPDATE_O)
    else $error("outputs not cleared by reset");

  cov_imm: cover property (IMM_UPDATE_O);
  cov_frame: cover property (FRAME_UPDATE_O);
  cov_obs: cover property (GPO_O != $past(GPO_NORMAL_I));
endmodule

bind ruc_update_ctrl ruc_update_ctrl_chk i_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SL_I(SL_I), .VD_I(VD_I),
  .GPO_NORMAL_I(GPO_NORMAL_I), .OUTPUT_GATE_CONTROL_I(OUTPUT_GATE_CONTROL_I),
  .HORIZONTAL_BLANKING_I(HORIZONTAL_BLANKING_I), .OPTICAL_BLACK_CLAMP_I(OPTICAL_BLACK_CLAMP_I),
  .PIXEL_BLANKING_I(PIXEL_BLANKING_I), .VERTICAL_CLOCK_15_I(VERTICAL_CLOCK_15_I),
  .VERTICAL_CLOCK_24_I(VERTICAL_CLOCK_24_I), .RD_ADDR_I(RD_ADDR_I), .RD_DATA_O(RD_DATA_O), .GPO_O(GPO_O),
  .VERTICAL_CLOCK_24_O(VERTICAL_CLOCK_24_O), .STARTUP_O(STARTUP_O), .IMM_UPDATE_O(IMM_UPDATE_O),
  .FRAME_UPDATE_O(FRAME_UPDATE_O));

// *** testbench/ruc_host_model.sv ***
// host model writing frames over the three-wire serial port
// assumes sampling on the serial clock rise while the strobe is low
`timescale 1ns/1ns
module ruc_host_model
  import ruc_pkg::*;
(
  output logic SCK_O,
  output logic SL_O,
  output logic SDATA_O
);
  initial
  begin
    SCK_O = 1'b0;
    SL_O = 1'b1;
    SDATA_O = 1'b0;
  end

  // address then data, lsb first; serial clock still outside frames
  task automatic send(input logic [7:0] a, input logic [27:0] d, input int nbits = 36);
    logic [35:0] f;
    f = {d, a};
    if (a == RUC_OBS_CTRL_OFS || a == RUC_SWAP_CTRL_OFS)
      f[35:8] = d & 28'h0000002;
    #37 SL_O = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      #40 SDATA_O = f[i];
      #40 SCK_O = 1'b1;
      #80 SCK_O = 1'b0;
    end
    #40 SL_O = 1'b1;
    SDATA_O = ~SDATA_O;
    #1000;
  endtask

  task automatic init();
    send(RUC_STARTUP_OFS, RUC_STARTUP_REC);
  endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the register update control block
// assumes the host model on the serial port and the bound checker
`timescale 1ns/1ns
module tb
  import ruc_pkg::*;
;
  logic        clk, rst, vd, ogc, hb, obc, pb, v15, v24, rd_v, rd_d, obs_m, swap_m;
  logic        v24o, imm, frm, sck, sl, sdata;
  logic [3:0]  gpo_n, gpo;
  logic [7:0]  rd_addr;
  logic [27:0] rd_data, startup, act [48], shd [48];
  logic [47:0] pend;
  logic [15:0] imm_m [3], frm_m [3];
  logic [31:0] seed;
  logic [27:0] rq [$];
  logic [4:0]  pq [$];
  int          fails, checks, imm_n, frm_n, imm_exp, frm_exp;

  ruc_update_ctrl i_dut (.CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .SL_I(sl), .SDATA_I(sdata), .VD_I(vd),
    .GPO_NORMAL_I(gpo_n), .OUTPUT_GATE_CONTROL_I(ogc), .HORIZONTAL_BLANKING_I(hb), .OPTICAL_BLACK_CLAMP_I(obc),
    .PIXEL_BLANKING_I(pb), .VERTICAL_CLOCK_15_I(v15), .VERTICAL_CLOCK_24_I(v24), .RD_ADDR_I(rd_addr),
    .RD_DATA_O(rd_data), .GPO_O(gpo), .VERTICAL_CLOCK_24_O(v24o), .STARTUP_O(startup), .IMM_UPDATE_O(imm),
    .FRAME_UPDATE_O(frm));
  ruc_host_model i_host (.SCK_O(sck), .SL_O(sl), .SDATA_O(sdata));

  // ********
  // helpers
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_word(input string name, input logic [27:0] e, input logic [27:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmp_pins(input logic [4:0] e, input logic [4:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD pins expected %h seen %h", e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // read one address with random pin inputs, noting both expectations
  task automatic probe(input logic [7:0] a, input logic [27:0] e);
    logic [31:0] r;
    @(posedge clk);
    r = rnd();
    rd_addr <= a;
    rd_v <= 1'b1;
    gpo_n <= r[3:0];
    {pb, obc, hb, ogc} <= r[7:4];
    v15 <= r[8];
    v24 <= r[9];
    rq.push_back(e);
    pq.push_back({swap_m ? r[8] : r[9], obs_m ? r[7:4] : r[3:0]});
    @(posedge clk);
    rd_v <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [27:0] d);
    int g;
    g = a[5:4];
    if (a <= RUC_BANK_END && imm_m[g][a[3:0]])
    begin
      act[a] = d;
      pend[a] = 1'b0;
      imm_exp++;
    end
    else if (a <= RUC_BANK_END)
    begin
      shd[a] = d;
      pend[a] = frm_m[g][a[3:0]];
    end
    if (a >= RUC_FE_IMM_OFS && a <= RUC_SYNC_FRM_OFS && a[0])
      frm_m[a[2:1]] = d[15:0];
    else if (a >= RUC_FE_IMM_OFS && a <= RUC_SYNC_FRM_OFS)
      imm_m[a[2:1]] = d[15:0];
    i_host.send(a, d);
    if (a == RUC_OBS_CTRL_OFS)
      obs_m = d[1];
    if (a == RUC_SWAP_CTRL_OFS)
      swap_m = d[1];
  endtask

  task automatic vsync();
    @(posedge clk);
    vd <= 1'b1;
    if (pend != '0)
      frm_exp++;
    for (int i = 0; i < 48; i++)
      if (pend[i])
        act[i] = shd[i];
    pend = '0;
    repeat (10) @(posedge clk);
    vd <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  // ********
  // monitor
  // ********
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      cmp_word("read data", rq.pop_front(), rd_data);
      cmp_pins(pq.pop_front(), {v24o, gpo});
    end
    rd_d <= rd_v;
    if (imm === 1'b1)
      imm_n++;
    if (frm === 1'b1)
      frm_n++;
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #1000000;
    fails++;
    close_out();
  end

  // ********
  // main sequence
  // ********
  initial
  begin
    logic [31:0] r;
    logic [3:0]  n, m, k;
    logic [7:0]  b;
    logic [15:0] fm;
    logic [7:0]  ofs [11];
    logic [27:0] rv [11];
    ofs = '{RUC_FE_IMM_OFS, RUC_FE_FRM_OFS, RUC_MISC_IMM_OFS, RUC_MISC_FRM_OFS, RUC_SYNC_IMM_OFS,
            RUC_SYNC_FRM_OFS, RUC_OBS_CTRL_OFS, RUC_SWAP_CTRL_OFS, RUC_STARTUP_OFS, 8'hC0, 8'h00};
    rv = '{RUC_FE_IMM_RST, RUC_FE_FRM_RST, RUC_MISC_IMM_RST, RUC_MISC_FRM_RST, RUC_SYNC_IMM_RST,
           RUC_SYNC_FRM_RST, RUC_OBS_CTRL_RST, RUC_SWAP_RST, RUC_STARTUP_RST, 28'h0, 28'h0};
    imm_m = '{RUC_FE_IMM_RST, RUC_MISC_IMM_RST, RUC_SYNC_IMM_RST};
    frm_m = '{RUC_FE_FRM_RST, RUC_MISC_FRM_RST, RUC_SYNC_FRM_RST};
    {rst, vd, ogc, hb, obc, pb, v15, v24, rd_v, rd_d, obs_m, swap_m} = 12'h800;
    {gpo_n, rd_addr, pend, seed} = {12'h0, 48'h0, 32'h40};
    {fails, checks, imm_n, frm_n, imm_exp, frm_exp} = '0;
    for (int i = 0; i < 48; i++)
      act[i] = 28'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      probe(ofs[i], rv[i]);
    i_host.init();
    probe(RUC_STARTUP_OFS, RUC_STARTUP_REC);
    cmp_word("start-up pins", RUC_STARTUP_REC, startup);
    for (int g = 0; g < 3; g++)
    begin
      r = rnd();
      n = r[3:0];
      m = n + 4'h1;
      k = n + 4'h2;
      b = 8'(g * 16);
      fm = ~((16'h0001 << n) | (16'h0001 << k));
      wr(RUC_FE_IMM_OFS + 8'(2 * g), 16'h0001 << n);
      wr(RUC_FE_FRM_OFS + 8'(2 * g), fm);
      probe(RUC_FE_FRM_OFS + 8'(2 * g), fm);
      wr(b + n, r[31:4]);
      wr(b + m, ~r[27:0]);
      wr(b + k, r[27:0]);
      probe(b + n, act[b + n]);
      probe(b + m, act[b + m]);
      vsync();
      probe(b + m, act[b + m]);
      probe(b + k, act[b + k]);
    end
    wr(RUC_OBS_CTRL_OFS, 28'h0000002);
    wr(RUC_SWAP_CTRL_OFS, 28'h0000002);
    probe(RUC_OBS_CTRL_OFS, 28'h0000002);
    repeat (6) probe(RUC_SWAP_CTRL_OFS, 28'h0000002);
    wr(RUC_OBS_CTRL_OFS, 28'h0);
    probe(RUC_FE_BASE, act[0]);
    wr(8'hC0, r[27:0]);
    i_host.send(RUC_FE_BASE, ~act[0], 8);
    probe(8'hC0, 28'h0);
    probe(RUC_FE_BASE, act[0]);
    repeat (4) @(posedge clk);
    cmp_word("immediate pulses", 28'(imm_exp), 28'(imm_n));
    cmp_word("frame pulses", 28'(frm_exp), 28'(frm_n));
    if (rq.size() != 0)
      fails++;
    close_out();
  end
endmodule
